// [inc/idf_pkg.sv]
// constants, types and register map of the accelerometer dual-channel and gyroscope filter block
// How it works
// - out of reset the accelerometer runs one channel whose full scale is set from 2 g up to 16 g.
// - the host writes the second-channel enable bit in control register eight, 1 turning channel two on and 0 off.
// - switching channel two on reaches channel one only through ready while interface batching is set; channel one keeps the scale held in its two-bit field.
// - while enabled, channel two delivers 16 g samples at the same rate as channel one.
// - channel two X, Y and Z sit as low/high byte pairs at 34h to 39h in two's complement.
// - channel two is shaped by the first low-pass filter of the accelerometer path.
// - with the interface batch bit set, every channel two sample is pushed into the fifo.
// - with the state-machine batch bit set, state-machine push commands put channel two samples into the fifo.
// - with channel two on, stabilisation accelerometer data is kept off the primary interface unless state-machine batching is on.
// - in modes 1 and 2 gyroscope data passes a selectable first low-pass filter and then a fixed second one.
// - the first gyroscope filter only acts in high-performance and high-accuracy modes and is bypassed in low power.
// - while a stabilisation chain runs, the first filter is withheld from the user interface chain.
// - the first gyroscope filter is enabled by a bit in control register seven, its cut-off chosen by a 3-bit field in register six.
// - the second gyroscope filter follows the gyroscope rate and is bypassed at 7680 Hz.
// - bandwidth codes 0xx all give one first-filter setting and only codes 100 to 111 narrow it.
package idf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// data carriers
	typedef logic [2:0][15:0] idf_axes_t;          // x, y, z as signed 16-bit words

	typedef struct packed {
		logic      from_fsm;                        // 1: pushed by a state-machine command
		idf_axes_t samp;                            // channel two sample
	} idf_fifo_word_t;

	typedef enum {BUF_EMPTY, BUF_ONE, BUF_TWO} idf_buf_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] OFF_FIFO_CONTROL_REGISTER_TWO = 8'h08;
	localparam logic [7:0] OFF_ACC_CTRL1  = 8'h10;
	localparam logic [7:0] OFF_CONTROL_REGISTER_SIX      = 8'h15;
	localparam logic [7:0] OFF_CONTROL_REGISTER_SEVEN      = 8'h16;
	localparam logic [7:0] OFF_CONTROL_REGISTER_EIGHT      = 8'h17;
	localparam logic [7:0] OFF_EMB_CFG    = 8'h63;
	localparam logic [7:0] OFF_CH2_X_L    = 8'h34;
	localparam logic [7:0] OFF_CH2_Z_H    = 8'h39;

	////////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int BIT_FS_LO       = 0;         // accel_full_scale_field [1:0] in register eight
	localparam int BIT_DUAL_EN     = 3;         // accel_second_channel_enable in register eight
	localparam int BIT_RATE_LO     = 4;         // accel_rate_field [7:4] in accel register one
	localparam int BIT_G_BW_LO     = 0;         // gyro_first_filter_bandwidth [2:0] in register six
	localparam int BIT_G_FIRST_LOWPASS_FILTER_EN   = 0;         // gyro_first_filter_enable in register seven
	localparam int BIT_IF_BATCH    = 3;         // ch2_interface_batch_bit
	localparam int BIT_FSM_BATCH   = 3;         // ch2_state_machine_batch_bit

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] RST_CTRL        = 8'h00;
	localparam logic [1:0] RST_FS          = 2'h0;
	localparam logic [3:0] RST_RATE        = 4'h0;
	localparam logic [2:0] RST_G_BW        = 3'h0;

	////////////////////////////////////////////////////////////////////////////////
	// filter settings, given as right shifts of a first-order smoother, and the gyroscope rate codes that select them
	localparam logic [2:0] ACC_FIRST_LOWPASS_FILTER_SHIFT  = 3'h1;
	localparam logic [2:0] G_FIRST_LOWPASS_FILTER_WIDE     = 3'h1;   // shared by codes 0xx
	localparam logic [3:0] G_RATE_7680     = 4'hc;   // gyroscope rate code of 7680 Hz
	localparam logic [3:0] G_RATE_FAST_MIN = 4'h9;
	localparam logic [2:0] G_SECOND_LOWPASS_FILTER_SLOW     = 3'h2;
	localparam logic [2:0] G_SECOND_LOWPASS_FILTER_FAST     = 3'h1;

endpackage

// [design/idf_lowpass.sv]
// three-axis first-order low-pass stage with bypass
`timescale 1ns/1ps
module idf_lowpass (
	// clock and reset
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	input  wire logic                 i_ce,
	// control
	input  wire logic                 i_bypass,
	input  wire logic [2:0]           i_shift,
	// sample in
	input  wire logic                 i_valid,
	input  wire idf_pkg::idf_axes_t   i_samp,
	// sample out
	output logic                      o_valid,
	output idf_pkg::idf_axes_t        o_samp
);

	////////////////////////////////////////////////////////////////////////////////
	// per-axis smoother: y moves toward x by (x - y) >>> shift, never overshoots
	idf_pkg::idf_axes_t nxt;

	genvar a;
	generate
		for (a = 0; a < 3; a++) begin : g_axis
			logic signed [16:0] diff;
			logic signed [16:0] step;
			logic signed [16:0] sum;
			assign diff   = $signed({i_samp[a][15], i_samp[a]}) - $signed({o_samp[a][15], o_samp[a]});
			assign step   = diff >>> i_shift;
			assign sum    = $signed({o_samp[a][15], o_samp[a]}) + step;
			assign nxt[a] = i_bypass ? i_samp[a] : sum[15:0];
		end
	endgenerate

	// one process owns the whole output word so it has a single driver
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_samp <= '0;
		end else if (i_ce && i_valid) begin
			o_samp <= nxt;
		end
	end

	// strobe is registered on the same edge as the data
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_valid <= 1'b0;
		end else if (i_ce) begin
			o_valid <= i_valid;
		end
	end

endmodule // idf_lowpass

// [design/idf_filter_cfg.sv]
// accelerometer dual-channel path, gyroscope filter chain and their registers
`timescale 1ns/1ps
module idf_filter_cfg (
	// clock and reset
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_ce,
	// register port
	input  wire logic                   i_reg_wr,
	input  wire logic                   i_reg_rd,
	input  wire logic [7:0]             i_reg_addr,
	input  wire logic [7:0]             i_reg_wdata,
	output logic [7:0]                  o_reg_rdata,
	output logic                        o_reg_rvalid,
	// accelerometer raw samples at 16 g scale
	input  wire logic                   i_accel_valid,
	input  wire idf_pkg::idf_axes_t     i_accel_sample,
	output logic                        o_accel_ready,
	output logic                        o_accel_ch1_valid,
	output idf_pkg::idf_axes_t          o_accel_ch1,
	// state machine and stabilisation status
	input  wire logic                   i_fsm_push_cmd,
	output logic                        o_ois_primary_en,
	// fifo write side
	output logic                        o_fifo_valid,
	output idf_pkg::idf_fifo_word_t     o_fifo_word,
	input  wire logic                   i_fifo_ready,
	// gyroscope
	input  wire logic                   i_gyro_valid,
	input  wire idf_pkg::idf_axes_t     i_gyro_sample,
	input  wire logic [3:0]             i_gyro_rate,
	input  wire logic                   i_gyro_low_power,
	input  wire logic                   i_stab_chain_en,
	output logic                        o_gyro_valid,
	output idf_pkg::idf_axes_t          o_gyro_data
);

	////////////////////////////////////////////////////////////////////////////////
	// decoding helpers
	function automatic idf_pkg::idf_axes_t sat_scale(input idf_pkg::idf_axes_t raw, input logic [1:0] fs);
		idf_pkg::idf_axes_t r;
		logic signed [18:0] w;
		logic [1:0]         sh;
		r  = '0;
		sh = 2'h3 - fs;                              // 16 g raw, narrower scale means more gain
		for (int a = 0; a < 3; a++) begin
			w = $signed({{3{raw[a][15]}}, raw[a]}) <<< sh;
			if (w > 19'sh07fff) begin
				r[a] = 16'h7fff;
			end else if (w < 19'sh78000) begin
				r[a] = 16'h8000;
			end else begin
				r[a] = w[15:0];
			end
		end
		return r;
	endfunction

	function automatic logic [2:0] g_bw_shift(input logic [2:0] bw);
		case (bw)
			3'h4:    return 3'h2;
			3'h5:    return 3'h3;
			3'h6:    return 3'h4;
			3'h7:    return 3'h5;
			default: return idf_pkg::G_FIRST_LOWPASS_FILTER_WIDE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// configuration bits
	logic [1:0] fs_q;
	logic       dual_en_q;
	logic [3:0] rate_q;
	logic [2:0] g_bw_q;
	logic       g_first_lowpass_filter_en_q;
	logic       if_batch_q;
	logic       fsm_batch_q;

	// host writes land in one cycle; unmapped and read-only offsets ignore writes
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			fs_q        <= idf_pkg::RST_FS;
			dual_en_q   <= 1'b0;
			rate_q      <= idf_pkg::RST_RATE;
			g_bw_q      <= idf_pkg::RST_G_BW;
			g_first_lowpass_filter_en_q <= 1'b0;
			if_batch_q  <= 1'b0;
			fsm_batch_q <= 1'b0;
		end else if (i_ce && i_reg_wr) begin
			case (i_reg_addr)
				idf_pkg::OFF_CONTROL_REGISTER_EIGHT: begin
					fs_q      <= i_reg_wdata[idf_pkg::BIT_FS_LO +: 2];
					dual_en_q <= i_reg_wdata[idf_pkg::BIT_DUAL_EN];
				end
				idf_pkg::OFF_ACC_CTRL1: rate_q      <= i_reg_wdata[idf_pkg::BIT_RATE_LO +: 4];
				idf_pkg::OFF_CONTROL_REGISTER_SIX:     g_bw_q      <= i_reg_wdata[idf_pkg::BIT_G_BW_LO +: 3];
				idf_pkg::OFF_CONTROL_REGISTER_SEVEN:     g_first_lowpass_filter_en_q <= i_reg_wdata[idf_pkg::BIT_G_FIRST_LOWPASS_FILTER_EN];
				idf_pkg::OFF_EMB_CFG:   if_batch_q  <= i_reg_wdata[idf_pkg::BIT_IF_BATCH];
				idf_pkg::OFF_FIFO_CONTROL_REGISTER_TWO: fsm_batch_q <= i_reg_wdata[idf_pkg::BIT_FSM_BATCH];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// accelerometer channel one and two
	idf_pkg::idf_axes_t ch2_filt;
	idf_pkg::idf_axes_t ch2_q;
	logic               ch2_filt_valid;
	logic               accept;
	logic               batching;

	assign batching = dual_en_q && if_batch_q;
	assign accept   = i_accel_valid && o_accel_ready;

	// channel one sees the dual enable only through ready, while interface batching is on
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_accel_ch1       <= '0;
			o_accel_ch1_valid <= 1'b0;
		end else if (i_ce) begin
			o_accel_ch1_valid <= accept;
			if (accept) begin
				o_accel_ch1 <= sat_scale(i_accel_sample, fs_q);
			end
		end
	end

	// channel two rides the same strobe, so it shares the rate of channel one
	idf_lowpass u_acc_first_lowpass_filter (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_bypass   (1'b0),
		.i_shift    (idf_pkg::ACC_FIRST_LOWPASS_FILTER_SHIFT),
		.i_valid    (accept && dual_en_q),
		.i_samp     (i_accel_sample),
		.o_valid    (ch2_filt_valid),
		.o_samp     (ch2_filt)
	);

	// output bytes hold the last sample once channel two is switched off
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ch2_q <= '0;
		end else if (i_ce && ch2_filt_valid && dual_en_q) begin
			ch2_q <= ch2_filt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register reads, answered one cycle after the strobe
	logic [7:0] rdata_d;
	logic [7:0] ch2_idx;

	assign ch2_idx = i_reg_addr - idf_pkg::OFF_CH2_X_L;

	always_comb begin
		rdata_d = 8'h00;
		case (i_reg_addr)
			idf_pkg::OFF_CONTROL_REGISTER_EIGHT: begin
				rdata_d[idf_pkg::BIT_FS_LO +: 2]  = fs_q;
				rdata_d[idf_pkg::BIT_DUAL_EN]     = dual_en_q;
			end
			idf_pkg::OFF_ACC_CTRL1:  rdata_d[idf_pkg::BIT_RATE_LO +: 4]  = rate_q;
			idf_pkg::OFF_CONTROL_REGISTER_SIX:      rdata_d[idf_pkg::BIT_G_BW_LO +: 3]  = g_bw_q;
			idf_pkg::OFF_CONTROL_REGISTER_SEVEN:      rdata_d[idf_pkg::BIT_G_FIRST_LOWPASS_FILTER_EN]     = g_first_lowpass_filter_en_q;
			idf_pkg::OFF_EMB_CFG:    rdata_d[idf_pkg::BIT_IF_BATCH]      = if_batch_q;
			idf_pkg::OFF_FIFO_CONTROL_REGISTER_TWO: rdata_d[idf_pkg::BIT_FSM_BATCH]     = fsm_batch_q;
			default: begin
				if (i_reg_addr >= idf_pkg::OFF_CH2_X_L && i_reg_addr <= idf_pkg::OFF_CH2_Z_H) begin
					// low byte at the even index, two's complement as stored
					rdata_d = ch2_q[ch2_idx[2:1]][ch2_idx[0]*8 +: 8];
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end else if (i_ce) begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= rdata_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fifo feed: two-entry buffer, interface pushes beat state-machine pushes
	idf_pkg::idf_buf_state_t state_q;
	idf_pkg::idf_buf_state_t state_d;
	idf_pkg::idf_fifo_word_t ent_q [2];
	idf_pkg::idf_fifo_word_t push_word;
	logic                    push_if;
	logic                    push_fsm;
	logic                    push;
	logic                    pop;
	logic                    pend_q;

	assign push_if   = ch2_filt_valid && batching;
	// a command waits while an interface sample is taken or in flight
	assign push_fsm  = pend_q && !push_if && !(accept && batching) && state_q != idf_pkg::BUF_TWO;
	assign push      = push_if || push_fsm;
	assign pop       = o_fifo_valid && i_fifo_ready;
	assign push_word = push_if ? idf_pkg::idf_fifo_word_t'{from_fsm: 1'b0, samp: ch2_filt}
	                           : idf_pkg::idf_fifo_word_t'{from_fsm: 1'b1, samp: ch2_q};

	// a command arriving as the previous one is served stays pending
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			pend_q <= 1'b0;
		end else if (i_ce) begin
			pend_q <= (i_fsm_push_cmd && fsm_batch_q) || (pend_q && !push_fsm);
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			idf_pkg::BUF_EMPTY: if (push) state_d = idf_pkg::BUF_ONE;
			idf_pkg::BUF_ONE:   if (push && !pop) state_d = idf_pkg::BUF_TWO;
			                    else if (!push && pop) state_d = idf_pkg::BUF_EMPTY;
			idf_pkg::BUF_TWO:   if (pop && !push) state_d = idf_pkg::BUF_ONE;
			default:            state_d = idf_pkg::BUF_EMPTY;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_q <= idf_pkg::BUF_EMPTY;
		end else if (i_ce) begin
			state_q <= state_d;
		end
	end

	// head always in slot zero so the output word is a flop
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			ent_q[0] <= '0;
			ent_q[1] <= '0;
		end else if (i_ce) begin
			if ((state_q == idf_pkg::BUF_EMPTY && push) || (state_q == idf_pkg::BUF_ONE && push && pop)) begin
				ent_q[0] <= push_word;
			end else if (pop && state_q == idf_pkg::BUF_TWO) begin
				ent_q[0] <= ent_q[1];
			end
			if (push && ((state_q == idf_pkg::BUF_ONE && !pop) || state_q == idf_pkg::BUF_TWO)) begin
				ent_q[1] <= push_word;
			end
		end
	end

	assign o_fifo_word = ent_q[0];

	// ready counts the sample still inside the filter; at most two samples in three cycles while batching
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_fifo_valid  <= 1'b0;
			o_accel_ready <= 1'b1;
		end else if (i_ce) begin
			o_fifo_valid  <= state_d != idf_pkg::BUF_EMPTY;
			o_accel_ready <= !batching || state_d == idf_pkg::BUF_EMPTY ||
			                 (state_d == idf_pkg::BUF_ONE && !accept);
		end
	end

	// stabilisation data reaches the primary side only when allowed
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_ois_primary_en <= 1'b1;
		end else if (i_ce) begin
			o_ois_primary_en <= !dual_en_q || fsm_batch_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// gyroscope chain: first filter then second filter
	logic               g1_bypass;
	logic               g2_bypass;
	logic [2:0]         g1_shift;
	logic [2:0]         g2_shift;
	logic               g1_valid;
	idf_pkg::idf_axes_t g1_samp;

	assign g1_bypass = !g_first_lowpass_filter_en_q || i_gyro_low_power || i_stab_chain_en;
	assign g1_shift  = g_bw_shift(g_bw_q);
	assign g2_bypass = i_gyro_rate == idf_pkg::G_RATE_7680 || i_gyro_low_power;
	assign g2_shift  = (i_gyro_rate >= idf_pkg::G_RATE_FAST_MIN) ? idf_pkg::G_SECOND_LOWPASS_FILTER_FAST : idf_pkg::G_SECOND_LOWPASS_FILTER_SLOW;

	idf_lowpass u_g_first_lowpass_filter (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_bypass   (g1_bypass),
		.i_shift    (g1_shift),
		.i_valid    (i_gyro_valid),
		.i_samp     (i_gyro_sample),
		.o_valid    (g1_valid),
		.o_samp     (g1_samp)
	);

	idf_lowpass u_g_second_lowpass_filter (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_bypass   (g2_bypass),
		.i_shift    (g2_shift),
		.i_valid    (g1_valid),
		.i_samp     (g1_samp),
		.o_valid    (o_gyro_valid),
		.o_samp     (o_gyro_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence s_gyro_lp;
		i_gyro_valid && i_gyro_low_power && i_ce ##1 i_gyro_low_power && i_ce ##1 1'b1;
	endsequence

	sequence s_ch2_read;
		i_ce && i_reg_rd && i_reg_addr == idf_pkg::OFF_CH2_X_L;
	endsequence

	chk_reset_single: assert property ($past(i_rst) |-> !dual_en_q && fs_q == idf_pkg::RST_FS)
		else $error("dual channel or scale not cleared by reset");
	chk_dual_write: assert property (i_ce && i_reg_wr && i_reg_addr == idf_pkg::OFF_CONTROL_REGISTER_EIGHT
		|=> dual_en_q == $past(i_reg_wdata[idf_pkg::BIT_DUAL_EN]))
		else $error("dual enable write not taken");
	chk_ch1_scale: assert property (i_ce && accept |=> o_accel_ch1_valid &&
		o_accel_ch1 == sat_scale($past(i_accel_sample), $past(fs_q)))
		else $error("channel one scaling wrong");
	chk_ch2_update: assert property (i_ce && accept && dual_en_q ##1 i_ce && dual_en_q
		|=> ch2_q == $past(ch2_filt))
		else $error("channel two result not stored");
	chk_ch2_readback: assert property (s_ch2_read |=> o_reg_rvalid && o_reg_rdata == $past(ch2_q[0][7:0]))
		else $error("channel two low byte read wrong");
	chk_if_batch: assert property (i_ce && ch2_filt_valid && batching |-> push ##1 o_fifo_valid)
		else $error("interface batch sample not queued");
	chk_fsm_pending: assert property (i_ce && i_fsm_push_cmd && fsm_batch_q |=> pend_q)
		else $error("state-machine push lost");
	chk_ois_gate: assert property (i_ce |=> o_ois_primary_en == $past(!dual_en_q || fsm_batch_q))
		else $error("primary access gate wrong");
	chk_gyro_lp_pass: assert property (s_gyro_lp |-> o_gyro_valid && o_gyro_data == $past(i_gyro_sample, 2))
		else $error("low-power gyro not passed straight");
	chk_stab_first_lowpass_filter: assert property (i_stab_chain_en |-> g1_bypass)
		else $error("first filter used beside stabilisation chain");
	chk_second_lowpass_filter_7680: assert property (i_gyro_rate == idf_pkg::G_RATE_7680 |-> g2_bypass)
		else $error("second filter active at 7680 Hz");
	chk_bw_wide: assert property (!g_bw_q[2] |-> g1_shift == idf_pkg::G_FIRST_LOWPASS_FILTER_WIDE)
		else $error("0xx codes not equal");

	// no-overflow guard of the two-entry buffer
	chk_buf_overflow: assert property (state_q == idf_pkg::BUF_TWO && !pop |-> !push)
		else $error("push into full buffer");

endmodule // idf_filter_cfg

// [verification/idf_fifo_sink.sv]
// fifo write-side partner that takes channel two words with a wandering ready
`timescale 1ns/1ps
module idf_fifo_sink (
	// clock and stall control
	input  wire logic                    i_core_clk,
	input  wire logic                    i_stall,
	// word stream from the block
	input  wire logic                    i_valid,
	input  wire idf_pkg::idf_fifo_word_t i_word,
	output logic                         o_ready
);
	idf_pkg::idf_fifo_word_t got[$];

	initial o_ready = 1'b0;

	// a word counts only when valid meets ready; ready drops at random so slow pops happen too
	always @(posedge i_core_clk) begin
		if (i_valid && o_ready)
			got.push_back(i_word);
		o_ready <= !i_stall && ($urandom % 3 != 0);
	end
endmodule // idf_fifo_sink

// [verification/idf_filter_cfg_tb.sv]
// self-checking bench for the dual-channel accelerometer and gyroscope filter block
`timescale 1ns/1ps
module idf_filter_cfg_tb;
	logic                    clk, rst, ce, wr, rd, av, fsm, gv, glp, stab, stall;
	logic                    rvalid, ardy, c1v, fv, frdy, gov, optical_stabilisation_chain, dual, ifb;
	logic [7:0]              addr, wdata, rdata;
	logic [3:0]              grate;
	logic [1:0]              fs;
	idf_pkg::idf_axes_t      asmp, gsmp, c1, gout;
	idf_pkg::idf_fifo_word_t fword, expq[$];
	int                      miscompares, check_count, y[3];

	idf_filter_cfg dut (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_accel_valid(av), .i_accel_sample(asmp), .o_accel_ready(ardy), .o_accel_ch1_valid(c1v),
		.o_accel_ch1(c1), .i_fsm_push_cmd(fsm), .o_ois_primary_en(optical_stabilisation_chain), .o_fifo_valid(fv),
		.o_fifo_word(fword), .i_fifo_ready(frdy), .i_gyro_valid(gv), .i_gyro_sample(gsmp),
		.i_gyro_rate(grate), .i_gyro_low_power(glp), .i_stab_chain_en(stab), .o_gyro_valid(gov),
		.o_gyro_data(gout));
	idf_fifo_sink sink (.i_core_clk(clk), .i_stall(stall), .i_valid(fv), .i_word(fword), .o_ready(frdy));

	// 40 MHz core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////
	// comparisons and verdict
	task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmp_word(input string n, input logic [48:0] e, input logic [48:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////
	// stimulus helpers; channel two model only moves while dual mode is on
	function automatic idf_pkg::idf_axes_t rnd_axes();
		for (int i = 0; i < 3; i++)
			rnd_axes[i] = 16'($signed(14'($urandom)));
	endfunction
	function automatic idf_pkg::idf_axes_t ymodel();
		for (int i = 0; i < 3; i++)
			ymodel[i] = 16'(y[i]);
	endfunction
	task automatic do_reset(input int n);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 3; i++)
			y[i] = 0;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp_byte("rvalid", 8'h01, {7'h0, rvalid});
		cmp_byte("rdata", e, rdata);
	endtask
	task automatic read_ch2();
		repeat (2) @(posedge clk);
		for (int a = 0; a < 6; a++)
			reg_rd(8'(idf_pkg::OFF_CH2_X_L + a), 8'(y[a / 2] >> (8 * (a % 2))));
	endtask
	task automatic chk_ois(input logic e);
		repeat (2) @(posedge clk);
		#1;
		cmp_byte("ois_primary", {7'h0, e}, {7'h0, optical_stabilisation_chain});
	endtask
	// the sample is held until ready is seen high at the taking edge
	task automatic send_acc(input idf_pkg::idf_axes_t s);
		int n;
		int v;
		idf_pkg::idf_axes_t e;
		@(posedge clk);
		av <= 1'b1;
		asmp <= s;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ardy !== 1'b1 && n < 100);
		if (n >= 100) begin
			miscompares++;
			give_verdict();
		end
		@(posedge clk);
		av <= 1'b0;
		#1;
		for (int i = 0; i < 3; i++) begin
			v = $signed(s[i]) <<< (3 - fs);
			v = (v > 32767) ? 32767 : (v < -32768) ? -32768 : v;
			e[i] = 16'(v);
			if (dual)
				y[i] = y[i] + ((int'($signed(s[i])) - y[i]) >>> 1);
		end
		if (dual && ifb)
			expq.push_back({1'b0, ymodel()});
		cmp_byte("ch1_valid", 8'h01, {7'h0, c1v});
		cmp_word("ch1", {1'b0, e}, {1'b0, c1});
	endtask
	task automatic pulse_fsm();
		@(posedge clk);
		fsm <= 1'b1;
		@(posedge clk);
		fsm <= 1'b0;
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (sink.got.size() < expq.size() && n < 200) begin
			@(posedge clk);
			n++;
		end
		repeat (6) @(posedge clk);
		cmp_byte("fifo_count", 8'(expq.size()), 8'(sink.got.size()));
		while (expq.size() > 0 && sink.got.size() > 0)
			cmp_word("fifo_word", expq.pop_front(), sink.got.pop_front());
	endtask
	// gyro chain from a cleared state: one sample leaves each smoother at x >>> k
	function automatic logic [15:0] gexp(input logic [15:0] x, input logic [2:0] b, input logic en,
		input logic lp, input logic st, input logic [3:0] r);
		int v;
		v = $signed(x);
		if (en && !lp && !st)
			v = v >>> (b[2] ? int'(b) - 2 : 1);
		if (!lp && r != idf_pkg::G_RATE_7680)
			v = v >>> ((r >= idf_pkg::G_RATE_FAST_MIN) ? 1 : 2);
		return 16'(v);
	endfunction

	////////////////////////////////////////
	// main sequence
	initial begin
		{wr, rd, av, fsm, gv, glp, stab, stall, rst, dual, ifb, fs} = '0;
		{addr, wdata, asmp, gsmp, grate} = '0;
		ce = 1'b1;
		void'($urandom(32));
		do_reset(10);
		reg_rd(8'h00, 8'h00);
		ce <= 1'b0;
		reg_wr(idf_pkg::OFF_CONTROL_REGISTER_EIGHT, 8'h08);
		ce <= 1'b1;
		reg_rd(idf_pkg::OFF_CONTROL_REGISTER_EIGHT, idf_pkg::RST_CTRL);
		reg_wr(idf_pkg::OFF_CH2_X_L, 8'hff);
		read_ch2();
		chk_ois(1'b1);
		reg_wr(idf_pkg::OFF_ACC_CTRL1, 8'ha0);
		reg_rd(idf_pkg::OFF_ACC_CTRL1, 8'ha0);
		for (int f = 0; f < 4; f++) begin
			fs = 2'(f);
			reg_wr(idf_pkg::OFF_CONTROL_REGISTER_EIGHT, {6'h0, fs});
			send_acc(rnd_axes());
		end
		dual = 1'b1;
		fs = 2'h1;
		reg_wr(idf_pkg::OFF_CONTROL_REGISTER_EIGHT, {4'h0, dual, 1'b0, fs});
		chk_ois(1'b0);
		repeat (3) send_acc(rnd_axes());
		read_ch2();
		dual = 1'b0;
		reg_wr(idf_pkg::OFF_CONTROL_REGISTER_EIGHT, {4'h0, dual, 1'b0, fs});
		send_acc(rnd_axes());
		read_ch2();
		dual = 1'b1;
		reg_wr(idf_pkg::OFF_CONTROL_REGISTER_EIGHT, {4'h0, dual, 1'b0, fs});
		pulse_fsm();
		drain();
		reg_wr(idf_pkg::OFF_FIFO_CONTROL_REGISTER_TWO, 8'h08);
		chk_ois(1'b1);
		expq.push_back({1'b1, ymodel()});
		pulse_fsm();
		drain();
		ifb = 1'b1;
		stall <= 1'b1;
		reg_wr(idf_pkg::OFF_EMB_CFG, 8'h08);
		repeat (2) send_acc(rnd_axes());
		repeat (4) @(posedge clk);
		#1;
		cmp_byte("accel_ready", 8'h00, {7'h0, ardy});
		stall <= 1'b0;
		send_acc(rnd_axes());
		drain();
		for (int c = 0; c < 12; c++) begin
			logic [3:0] r;
			idf_pkg::idf_axes_t s, e;
			r = (c == 11) ? 4'hc : 4'($urandom % 12);
			do_reset(2);
			glp <= (c == 10);
			stab <= (c == 9);
			grate <= r;
			reg_wr(idf_pkg::OFF_CONTROL_REGISTER_SIX, 8'(c % 8));
			reg_wr(idf_pkg::OFF_CONTROL_REGISTER_SEVEN, {7'h0, c != 8});
			s = rnd_axes();
			for (int i = 0; i < 3; i++)
				e[i] = gexp(s[i], 3'(c), c != 8, c == 10, c == 9, r);
			@(posedge clk);
			gv <= 1'b1;
			gsmp <= s;
			@(posedge clk);
			gv <= 1'b0;
			@(posedge clk);
			#1;
			cmp_byte("gyro_valid", 8'h01, {7'h0, gov});
			cmp_word("gyro", {1'b0, e}, {1'b0, gout});
		end
		give_verdict();
	end
endmodule // idf_filter_cfg_tb
